/* File: design/tsas_params.svh */
// Register offsets, field positions, reset values and timing figures of the sequencer
`ifndef TSAS_PARAMS_SVH
`define TSAS_PARAMS_SVH
`define TSAS_ADDR_CTRL 8'h00
`define TSAS_ADDR_SLOT 8'h04
`define TSAS_ADDR_DELAY 8'h08
`define TSAS_ADDR_STATUS 8'h0C
`define TSAS_ADDR_MASK 8'h10
`define TSAS_RESULT_SEL 3'h1
`define TSAS_CTRL_TEN 0
`define TSAS_CTRL_PEN 1
`define TSAS_CTRL_TTRIG 2
`define TSAS_CTRL_OTRIG 3
`define TSAS_CTRL_OCH_LSB 4
`define TSAS_CTRL_OSLOT_LSB 8
`define TSAS_SLOT_LAST_LSB 16
`define TSAS_DLY_FIRST_LSB 0
`define TSAS_DLY_BETWEEN_LSB 4
`define TSAS_DLY_AFTER_LSB 8
`define TSAS_ST_DONE 0
`define TSAS_ST_PEN 1
`define TSAS_ST_ORD 2
`define TSAS_ST_TMO 3
`define TSAS_ST_BUSY 4
`define TSAS_ST_CAL 5
`define TSAS_SLOT_RST 16'h0000
`define TSAS_LAST_RST 3'h0
`define TSAS_DLY_RST 4'h0
`define TSAS_MASK_RST 3'h7
`define TSAS_CH_TEMP 4'h3
`define TSAS_CH_CELL 4'h8
`define TSAS_CH_AUX_LO 4'h9
`define TSAS_CH_AUX_HI 4'hB
`define TSAS_CH_XA 4'hC
`define TSAS_CH_YA 4'hE
`define TSAS_CH_YB 4'hF
`define TSAS_CLK_MHZ 25
`define TSAS_CLK_KHZ 25000
`define TSAS_CONV_CLK_KHZ 1330
`define TSAS_DLY_STEP_US 40
`define TSAS_CONV_MAX_US 10
`define TSAS_TURN_ON_US 31
`endif

/* File: design/tsas_pkg.sv */
// Types shared by the touch screen sequencer files
package tsas_pkg;
    typedef enum logic [2:0]
    {
        S_CAL = 3'h0,
        S_IDLE = 3'h1,
        S_WARM = 3'h2,
        S_DLY1 = 3'h3,
        S_CONV = 3'h4,
        S_DLY2 = 3'h5,
        S_DLY3 = 3'h6
    } tsas_state_t;
    typedef enum logic [1:0]
    {
        ACT_DUMMY = 2'h0,
        ACT_XPLATE = 2'h1,
        ACT_YPLATE = 2'h2,
        ACT_CONTACT = 2'h3
    } tsas_action_t;
endpackage : tsas_pkg

/* File: design/tsas_result_mem.sv */
// Eight-word result memory with registered read data
module tsas_result_mem
    import tsas_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire logic [9:0] wdata,
    input wire logic [2:0] raddr,
    output logic [9:0] rdata
);
    logic [9:0] mem [8];

    // Write port
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata <= 10'h000;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end
endmodule : tsas_result_mem

/* File: design/tsas_top.sv */
// Touch screen converter sequencer with APB register file
// Function
// - Channels 0-2 and 4-7 are reserved; they give no measurement.
// - Channel 3 is die temperature, code 680 at 25 C, 0.426 C per step.
// - Channel 8 is coin-cell voltage times two thirds.
// - Coin-cell channel stays convertible below the cell disconnect threshold.
// - Channels 9 to 11 are three external analog inputs.
// - Without touch use, plate pins are channels 12 to 15 in order.
// - Pen sensed with pen bias on sets pen flag and interrupt unless masked.
// - Pen detection works only while touch enable is low.
// - Touch bias supply on for touch conversions, off for others.
// - X reading is a 10-bit coordinate, zero at the X+ edge.
// - Y reading is a 10-bit coordinate, zero at Y-, 1023 at Y+.
// - Contact reading is contact voltage from known current, times two.
// - X measurement drives bias across X pins, reads first Y pin.
// - Y measurement drives bias across Y pins, reads first X pin.
// - Contact: current into first Y, second X grounded, read Y2 minus X1.
// - Touch sequence runs slot 0 through the last-slot field.
// - Slot codes: 00 dummy, 01 X plate, 10 Y plate, 11 contact.
// - Dummy conversion pre-biases references and returns zero.
// - Touch sequence has priority; touch results overwrite ordinary ones.
// - Three 4-bit delays, default zero: first, between, after.
// - Delay code step is 40 us, code 1111 gives 600 us.
// - Conversion ends within 10 us; converter turns on within 31 us.
// - Converter calibrates at power-up and runs on a 1.33 MHz clock.
`include "tsas_params.svh"
module tsas_top
    import tsas_pkg::*;
#(
    parameter int DLY_STEP_CYCLES = `TSAS_DLY_STEP_US * `TSAS_CLK_MHZ
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic conv_clk_en,
    output logic conv_power,
    output logic conv_cal,
    output logic conv_start,
    output logic [3:0] conv_channel,
    output logic conv_diff_x2,
    input wire logic conv_done,
    input wire logic [9:0] conv_data,
    output logic touch_bias_supply,
    output logic xplate_pin_a_ref,
    output logic xplate_pin_b_gnd,
    output logic yplate_pin_a_ref,
    output logic yplate_pin_b_gnd,
    output logic yplate_pin_a_isrc,
    output logic pen_bias_on,
    input wire logic pen_sense,
    output logic host_irq
);
    localparam int CONV_MAX = `TSAS_CONV_MAX_US * `TSAS_CLK_MHZ;
    localparam int CONV_LIMIT = CONV_MAX + 1; // Timeout exit shows one cycle after the count
    localparam int TURN_ON = `TSAS_TURN_ON_US * `TSAS_CLK_MHZ;
    localparam int DIV = (`TSAS_CLK_KHZ + `TSAS_CONV_CLK_KHZ / 2) / `TSAS_CONV_CLK_KHZ;

    tsas_state_t state_q, state_d;
    logic [15:0] cnt_q;
    logic [2:0] slot_q, slot_d;
    logic mode_touch_q, mode_touch_d;
    logic touch_en_q, pen_en_q;
    logic [3:0] ord_ch_q;
    logic [2:0] ord_slot_q;
    logic [15:0] slots_q;
    logic [2:0] last_q;
    logic [3:0] dly_first_q, dly_between_q, dly_after_q;
    logic done_flag_q, pen_flag_q, ord_flag_q, tmo_flag_q;
    logic [2:0] mask_q;
    logic [31:0] rdata_q;
    logic rd_mem_q;
    logic [4:0] div_q;
    logic mem_we;
    logic [2:0] mem_waddr;
    logic [9:0] mem_wdata, mem_rdata;
    logic done_evt, ord_evt, tmo_evt;
    logic wr_acc, touch_go, ord_go;
    tsas_action_t act;

    // Delay code to clock cycles, 40 us per step
    function automatic logic [15:0] dly_cycles(input logic [3:0] code);
        dly_cycles = 16'(int'(code) * DLY_STEP_CYCLES);
    endfunction : dly_cycles

    // Channels that carry a defined measurement
    function automatic logic ch_valid(input logic [3:0] ch, input logic ten);
        logic ok;
        ok = 1'b0;
        if (ch == `TSAS_CH_TEMP || ch == `TSAS_CH_CELL)
        begin
            ok = 1'b1;
        end
        else if (ch >= `TSAS_CH_AUX_LO && ch <= `TSAS_CH_AUX_HI)
        begin
            ok = 1'b1;
        end
        else if (ch >= `TSAS_CH_XA)
        begin
            ok = !ten;
        end
        ch_valid = ok;
    endfunction : ch_valid

    // Byte address decode of the register file
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == `TSAS_ADDR_CTRL) || (a == `TSAS_ADDR_SLOT) ||
            (a == `TSAS_ADDR_DELAY) || (a == `TSAS_ADDR_STATUS) ||
            (a == `TSAS_ADDR_MASK) ||
            (a[7:5] == `TSAS_RESULT_SEL && a[1:0] == 2'h0);
    endfunction : reg_hit

    // APB handshake: zero wait states, error on unmapped address
    assign pready = 1'b1;
    assign pslverr = psel && penable && !reg_hit(paddr);
    assign wr_acc = psel && penable && pwrite;
    assign touch_go = wr_acc && paddr == `TSAS_ADDR_CTRL && pwdata[`TSAS_CTRL_TTRIG];
    assign ord_go = wr_acc && paddr == `TSAS_ADDR_CTRL && pwdata[`TSAS_CTRL_OTRIG];
    assign prdata = rd_mem_q ? {22'h0, mem_rdata} : rdata_q;
    assign act = tsas_action_t'(slots_q[2 * slot_q +: 2]);

    // Control and configuration registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            touch_en_q <= 1'b0;
            pen_en_q <= 1'b0;
            ord_ch_q <= 4'h0;
            ord_slot_q <= 3'h0;
            slots_q <= `TSAS_SLOT_RST;
            last_q <= `TSAS_LAST_RST;
            dly_first_q <= `TSAS_DLY_RST;
            dly_between_q <= `TSAS_DLY_RST;
            dly_after_q <= `TSAS_DLY_RST;
            mask_q <= `TSAS_MASK_RST;
        end
        else if (wr_acc)
        begin
            if (paddr == `TSAS_ADDR_CTRL)
            begin
                touch_en_q <= pwdata[`TSAS_CTRL_TEN];
                pen_en_q <= pwdata[`TSAS_CTRL_PEN];
                ord_ch_q <= pwdata[`TSAS_CTRL_OCH_LSB +: 4];
                ord_slot_q <= pwdata[`TSAS_CTRL_OSLOT_LSB +: 3];
            end
            if (paddr == `TSAS_ADDR_SLOT)
            begin
                slots_q <= pwdata[15:0];
                last_q <= pwdata[`TSAS_SLOT_LAST_LSB +: 3];
            end
            if (paddr == `TSAS_ADDR_DELAY)
            begin
                dly_first_q <= pwdata[`TSAS_DLY_FIRST_LSB +: 4];
                dly_between_q <= pwdata[`TSAS_DLY_BETWEEN_LSB +: 4];
                dly_after_q <= pwdata[`TSAS_DLY_AFTER_LSB +: 4];
            end
            if (paddr == `TSAS_ADDR_MASK)
            begin
                mask_q <= pwdata[2:0];
            end
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_q <= 32'h0000_0000;
            rd_mem_q <= 1'b0;
        end
        else if (psel && !penable)
        begin
            rd_mem_q <= paddr[7:5] == `TSAS_RESULT_SEL && paddr[1:0] == 2'h0;
            rdata_q <= 32'h0000_0000;
            unique case (paddr)
                `TSAS_ADDR_CTRL: rdata_q <= {21'h0, ord_slot_q, ord_ch_q, 2'h0,
                    pen_en_q, touch_en_q};
                `TSAS_ADDR_SLOT: rdata_q <= {13'h0, last_q, slots_q};
                `TSAS_ADDR_DELAY: rdata_q <= {20'h0, dly_after_q, dly_between_q,
                    dly_first_q};
                `TSAS_ADDR_STATUS: rdata_q <= {26'h0, state_q != S_CAL,
                    state_q != S_IDLE && state_q != S_CAL, tmo_flag_q, ord_flag_q,
                    pen_flag_q, done_flag_q};
                `TSAS_ADDR_MASK: rdata_q <= {29'h0, mask_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Sequencer next state
    always_comb
    begin
        state_d = state_q;
        slot_d = slot_q;
        mode_touch_d = mode_touch_q;
        mem_we = 1'b0;
        mem_waddr = slot_q;
        mem_wdata = 10'h000;
        done_evt = 1'b0;
        ord_evt = 1'b0;
        tmo_evt = 1'b0;
        unique case (state_q)
            S_CAL:
                if (cnt_q >= 16'(TURN_ON))
                begin
                    state_d = S_IDLE;
                end
            S_IDLE:
                if (touch_go && touch_en_q)
                begin
                    state_d = S_WARM;
                    slot_d = 3'h0;
                    mode_touch_d = 1'b1;
                end
                else if (ord_go && !ch_valid(pwdata[`TSAS_CTRL_OCH_LSB +: 4], touch_en_q))
                begin
                    mem_we = 1'b1;
                    mem_waddr = pwdata[`TSAS_CTRL_OSLOT_LSB +: 3];
                    ord_evt = 1'b1;
                end
                else if (ord_go)
                begin
                    state_d = S_WARM;
                    mode_touch_d = 1'b0;
                end
            S_WARM:
                if (cnt_q >= 16'(TURN_ON))
                begin
                    state_d = mode_touch_q ? S_DLY1 : S_CONV;
                end
            S_DLY1:
                if (cnt_q >= dly_cycles(dly_first_q))
                begin
                    state_d = S_CONV;
                end
            S_CONV:
                if (conv_done || cnt_q >= 16'(CONV_MAX))
                begin
                    mem_we = 1'b1;
                    tmo_evt = !conv_done;
                    if (mode_touch_q)
                    begin
                        // Touch data overwrite whatever slot they land in
                        mem_waddr = slot_q;
                        if (conv_done && act != ACT_DUMMY)
                        begin
                            mem_wdata = conv_data;
                        end
                        if (slot_q == last_q)
                        begin
                            state_d = S_DLY3;
                        end
                        else
                        begin
                            slot_d = slot_q + 3'h1;
                            state_d = S_DLY2;
                        end
                    end
                    else
                    begin
                        mem_waddr = ord_slot_q;
                        mem_wdata = conv_done ? conv_data : 10'h000;
                        ord_evt = 1'b1;
                        state_d = S_IDLE;
                    end
                end
            S_DLY2:
                if (cnt_q >= dly_cycles(dly_between_q))
                begin
                    state_d = S_CONV;
                end
            S_DLY3:
                if (cnt_q >= dly_cycles(dly_after_q))
                begin
                    done_evt = 1'b1;
                    state_d = S_IDLE;
                end
            default: state_d = S_IDLE;
        endcase
    end

    // Sequencer state and step counter
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= S_CAL;
            slot_q <= 3'h0;
            mode_touch_q <= 1'b0;
            cnt_q <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            slot_q <= slot_d;
            mode_touch_q <= mode_touch_d;
            if (state_d != state_q)
            begin
                cnt_q <= 16'h0000;
            end
            else if (cnt_q != 16'hFFFF)
            begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    // Converter control and plate switches, aligned with the state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            conv_power <= 1'b0;
            conv_cal <= 1'b0;
            conv_start <= 1'b0;
            conv_channel <= 4'h0;
            conv_diff_x2 <= 1'b0;
            touch_bias_supply <= 1'b0;
            xplate_pin_a_ref <= 1'b0;
            xplate_pin_b_gnd <= 1'b0;
            yplate_pin_a_ref <= 1'b0;
            yplate_pin_b_gnd <= 1'b0;
            yplate_pin_a_isrc <= 1'b0;
        end
        else
        begin
            conv_power <= state_d != S_IDLE;
            conv_cal <= state_d == S_CAL;
            conv_start <= state_d == S_CONV && state_q != S_CONV;
            touch_bias_supply <= mode_touch_d && state_d != S_IDLE && state_d != S_CAL;
            xplate_pin_a_ref <= 1'b0;
            xplate_pin_b_gnd <= 1'b0;
            yplate_pin_a_ref <= 1'b0;
            yplate_pin_b_gnd <= 1'b0;
            yplate_pin_a_isrc <= 1'b0;
            conv_diff_x2 <= 1'b0;
            conv_channel <= ord_ch_q;
            if (mode_touch_d && (state_d == S_DLY1 || state_d == S_CONV || state_d == S_DLY2))
            begin
                conv_channel <= `TSAS_CH_YA;
                unique case (tsas_action_t'(slots_q[2 * slot_d +: 2]))
                    ACT_XPLATE:
                    begin
                        xplate_pin_a_ref <= 1'b1;
                        xplate_pin_b_gnd <= 1'b1;
                    end
                    ACT_YPLATE:
                    begin
                        yplate_pin_a_ref <= 1'b1;
                        yplate_pin_b_gnd <= 1'b1;
                        conv_channel <= `TSAS_CH_XA;
                    end
                    ACT_CONTACT:
                    begin
                        yplate_pin_a_isrc <= 1'b1;
                        xplate_pin_b_gnd <= 1'b1;
                        conv_channel <= `TSAS_CH_YB;
                        conv_diff_x2 <= 1'b1;
                    end
                    ACT_DUMMY: conv_channel <= `TSAS_CH_YA;
                endcase
            end
        end
    end

    // Sticky status flags; a set beats a same-cycle clear
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            done_flag_q <= 1'b0;
            pen_flag_q <= 1'b0;
            ord_flag_q <= 1'b0;
            tmo_flag_q <= 1'b0;
        end
        else
        begin
            if (wr_acc && paddr == `TSAS_ADDR_STATUS)
            begin
                done_flag_q <= done_flag_q && !pwdata[`TSAS_ST_DONE];
                pen_flag_q <= pen_flag_q && !pwdata[`TSAS_ST_PEN];
                ord_flag_q <= ord_flag_q && !pwdata[`TSAS_ST_ORD];
                tmo_flag_q <= tmo_flag_q && !pwdata[`TSAS_ST_TMO];
            end
            if (done_evt)
            begin
                done_flag_q <= 1'b1;
            end
            if (pen_bias_on && pen_sense)
            begin
                pen_flag_q <= 1'b1;
            end
            if (ord_evt)
            begin
                ord_flag_q <= 1'b1;
            end
            if (tmo_evt)
            begin
                tmo_flag_q <= 1'b1;
            end
        end
    end

    // Pen bias, interrupt line and converter clock enable
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pen_bias_on <= 1'b0;
            host_irq <= 1'b0;
            div_q <= 5'h00;
            conv_clk_en <= 1'b0;
        end
        else
        begin
            pen_bias_on <= pen_en_q && !touch_en_q;
            host_irq <= |({ord_flag_q, pen_flag_q, done_flag_q} & ~mask_q);
            conv_clk_en <= div_q == 5'(DIV - 1);
            div_q <= (div_q == 5'(DIV - 1)) ? 5'h00 : div_q + 5'h01;
        end
    end

    tsas_result_mem u_mem (
        .clk(clk),
        .resetn(resetn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(paddr[4:2]),
        .rdata(mem_rdata)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence seq_conv_open;
        conv_start && state_q == S_CONV;
    endsequence

    sequence seq_conv_close;
        ##[1:CONV_LIMIT] state_q != S_CONV;
    endsequence

    a_reserved_chan: assert property ((state_q == S_IDLE && ord_go && !touch_go &&
        !ch_valid(pwdata[`TSAS_CTRL_OCH_LSB +: 4], touch_en_q)) |=>
        (state_q == S_IDLE && ord_flag_q))
        else $error("reserved channel started a conversion");
    a_pen_gate: assert property ($rose(pen_flag_q) |->
        $past(pen_en_q, 2) && !$past(touch_en_q, 2) && $past(pen_sense))
        else $error("pen flag set without pen bias");
    a_bias_ordinary: assert property ((state_q == S_CONV && !mode_touch_q) |->
        !touch_bias_supply)
        else $error("bias supply on in ordinary conversion");
    a_x_drive: assert property ((seq_conv_open and mode_touch_q && act == ACT_XPLATE) |->
        xplate_pin_a_ref && xplate_pin_b_gnd && conv_channel == `TSAS_CH_YA)
        else $error("x measurement drive wrong");
    a_y_drive: assert property ((seq_conv_open and mode_touch_q && act == ACT_YPLATE) |->
        yplate_pin_a_ref && yplate_pin_b_gnd && conv_channel == `TSAS_CH_XA)
        else $error("y measurement drive wrong");
    a_contact_drive: assert property ((seq_conv_open and mode_touch_q &&
        act == ACT_CONTACT) |-> yplate_pin_a_isrc && xplate_pin_b_gnd && conv_diff_x2 &&
        !xplate_pin_a_ref)
        else $error("contact measurement drive wrong");
    a_slot_start: assert property ((state_q == S_IDLE && touch_go && touch_en_q) |=>
        (slot_q == 3'h0 && state_q == S_WARM))
        else $error("touch sequence did not start at slot 0");
    a_done_after: assert property ($rose(done_flag_q) |-> $past(state_q) == S_DLY3)
        else $error("done flag before after-delay");
    a_conv_bound: assert property (seq_conv_open |-> seq_conv_close)
        else $error("conversion overran its time");
    a_dummy_zero: assert property ((mem_we && mode_touch_q && state_q == S_CONV &&
        act == ACT_DUMMY) |-> mem_wdata == 10'h000)
        else $error("dummy result not zero");
endmodule : tsas_top

/* File: verification/tsas_conv_model.sv */
// Behavioural converter that answers start pulses
module tsas_conv_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic conv_start,
    input wire logic [3:0] conv_channel,
    input wire logic conv_diff_x2,
    input wire logic mute,
    output logic conv_done,
    output logic [9:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy_q;
    logic slow_q;
    logic [4:0] cnt_q;
    logic [4:0] tag_q;
    // Prompt and slow answers alternate; data toggles when idle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_q <= 1'b0;
            slow_q <= 1'b0;
            cnt_q <= 5'h00;
            tag_q <= 5'h00;
            conv_done <= 1'b0;
            conv_data <= 10'h155;
        end
        else
        begin
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
            cnt_q <= cnt_q - 5'h01;
            if (conv_start && !mute)
            begin
                busy_q <= 1'b1;
                slow_q <= ~slow_q;
                cnt_q <= slow_q ? 5'h14 : 5'h01;
                tag_q <= {conv_channel, conv_diff_x2};
            end
            else if (busy_q && cnt_q == 5'h00)
            begin
                busy_q <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= {tag_q, 5'h0D};
            end
        end
    end
endmodule : tsas_conv_model

/* File: verification/tsas_top_test.sv */
// Self-checking bench for the touch screen sequencer
module tsas_top_test
    import tsas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pen_sense = 0, mute = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, conv_start, conv_done, diff, bias, host_irq, in_touch = 0;
    logic ce, pwr, cal, pbias;
    logic [3:0] conv_channel, och;
    logic [9:0] conv_data;
    logic [4:0] sw;
    logic [15:0] slots;
    int num_errors = 0, compares = 0, cycles = 0, seed = 32'h2135, n, i, gap = -99;
    initial forever #20 clk = ~clk;
    tsas_top #(.DLY_STEP_CYCLES(4)) dut (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_clk_en(ce), .conv_power(pwr), .conv_cal(cal),
        .conv_start(conv_start), .conv_channel(conv_channel), .conv_diff_x2(diff),
        .conv_done(conv_done), .conv_data(conv_data), .touch_bias_supply(bias),
        .xplate_pin_a_ref(sw[4]), .xplate_pin_b_gnd(sw[3]), .yplate_pin_a_ref(sw[2]),
        .yplate_pin_b_gnd(sw[1]), .yplate_pin_a_isrc(sw[0]), .pen_bias_on(pbias),
        .pen_sense(pen_sense), .host_irq(host_irq));
    tsas_conv_model model (.clk(clk), .resetn(resetn), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_diff_x2(diff), .mute(mute),
        .conv_done(conv_done), .conv_data(conv_data));
    // Value the converter model returns
    function automatic logic [9:0] conv_val(input logic [3:0] c, input logic d);
        return {c, d, 5'h0D};
    endfunction : conv_val
    // Channel, differential flag and switch set of each action
    function automatic logic [9:0] act_exp(input logic [1:0] a);
        case (a)
            ACT_XPLATE: return {4'hE, 1'b0, 5'h18};
            ACT_YPLATE: return {4'hC, 1'b0, 5'h06};
            ACT_CONTACT: return {4'hF, 1'b1, 5'h09};
            default: return {4'hE, 1'b0, 5'h00};
        endcase
    endfunction : act_exp
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x)
        begin
            $display("Error %s expected %h seen %h", nm, x, g);
            num_errors++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic touch_run(input logic [15:0] s, input logic [2:0] l, input logic [31:0] d,
        input logic m);
        logic [9:0] x;
        mute <= m;
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h04, {13'h0, l, s});
        apb(1'b1, 8'h08, d);
        slots = s;
        n = 0;
        in_touch = 1'b1;
        apb(1'b1, 8'h00, 32'h5);
        apb(1'b1, 8'h00, 32'h99);
        while (host_irq !== 1'b1)
            @(posedge clk);
        apb(1'b0, 8'h0C, 32'h0);
        chk("done", 32'h1, {31'h0, q[0]});
        chk("timeout", {31'h0, m}, {31'h0, q[3]});
        chk("count", 32'(l) + 1, n);
        for (int k = 0; k <= l; k++)
        begin
            apb(1'b0, 8'h20 + 8'(4 * k), 32'h0);
            x = act_exp(s[2*k +: 2]);
            x = (m || s[2*k +: 2] == ACT_DUMMY) ? 10'h000 : conv_val(x[9:6], x[5]);
            chk("result", {22'h0, x}, q);
        end
        apb(1'b1, 8'h0C, 32'hF);
    endtask : touch_run
    task automatic results;
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    // Hang limit and a look at every conversion start
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            num_errors++;
            results();
        end
        if (conv_start === 1'b1 && in_touch)
        begin
            chk("action", {22'h0, act_exp(slots[2*n +: 2])},
                {22'h0, conv_channel, diff, sw});
            n++;
        end
        if (conv_start === 1'b1)
        begin
            chk("bias", {31'h0, in_touch}, {31'h0, bias});
            chk("power", 32'h2, {30'h0, pwr, cal});
        end
        // Converter clock enable spacing
        gap++;
        if (ce === 1'b1)
        begin
            if (gap > 0)
                chk("clk_en", 32'h13, gap);
            gap = 0;
        end
        if (conv_start === 1'b1 && !in_touch)
            chk("channel", {28'h0, och}, {28'h0, conv_channel});
    end
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        apb(1'b0, 8'h10, 32'h0);
        chk("mask", 32'h7, {29'h0, q[2:0]});
        chk("cal", 32'h1, {31'h0, cal});
        apb(1'b0, 8'h04, 32'h0);
        chk("slot", 32'h0, {13'h0, q[18:0]});
        apb(1'b0, 8'h08, 32'h0);
        chk("delay", 32'h0, {20'h0, q[11:0]});
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        do
            apb(1'b0, 8'h0C, 32'h0);
        while (q[5] !== 1'b1);
        apb(1'b1, 8'h00, 32'h2);
        pen_sense <= 1'b1;
        repeat (5) @(posedge clk);
        chk("masked irq", 32'h0, {31'h0, host_irq});
        chk("pen bias", 32'h1, {31'h0, pbias});
        apb(1'b1, 8'h10, 32'h0);
        repeat (3) @(posedge clk);
        chk("pen irq", 32'h1, {31'h0, host_irq});
        pen_sense <= 1'b0;
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h0C, 32'h2);
        pen_sense <= 1'b1;
        repeat (5) @(posedge clk);
        apb(1'b1, 8'h0C, 32'h2);
        apb(1'b0, 8'h0C, 32'h0);
        chk("pen off", 32'h0, {31'h0, q[1]});
        chk("pen bias", 32'h0, {31'h0, pbias});
        pen_sense <= 1'b0;
        touch_run(16'hE4E4, 3'h7, 32'hFFF, 1'b0);
        for (i = 0; i < 3; i++)
            touch_run(16'($random(seed)), 3'($random(seed)), 32'($random(seed)) & 32'h333, 1'b0);
        touch_run(16'h0001, 3'h0, 32'h0, 1'b1);
        mute <= 1'b0;
        in_touch = 1'b0;
        apb(1'b1, 8'h00, 32'h0);
        for (i = 0; i < 16; i++)
        begin
            och = 4'(i);
            apb(1'b1, 8'h00, 32'h8 | 32'(i << 4) | 32'((i % 8) << 8));
            while (host_irq !== 1'b1)
                @(posedge clk);
            apb(1'b0, 8'h20 + 8'(4 * (i % 8)), 32'h0);
            chk("ordinary", (i < 3 || (i > 3 && i < 8)) ? 32'h0 :
                {22'h0, conv_val(och, 1'b0)}, q);
            apb(1'b1, 8'h0C, 32'h4);
        end
        results();
    end
endmodule : tsas_top_test
